// >>> verilog/mss_pkg.sv
// Package for the memory subsystem status register bank.
// Assumes a 32-bit APB with byte addresses; offsets are byte offsets.
package mss_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int FLAG_W = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_DDR_DMA_ERR_ADDR = 12'h0e0;
  localparam logic [ADDR_W-1:0] OFF_DDR_BUS_ERR_ADDR = 12'h0e4;
  localparam logic [ADDR_W-1:0] OFF_DDR_BUF_EMPTY    = 12'h0e8;
  localparam logic [ADDR_W-1:0] OFF_DDR_BUF_DISABLE  = 12'h0ec;
  localparam logic [ADDR_W-1:0] OFF_SRAM0_ERR_COUNT  = 12'h0f0;
  localparam logic [ADDR_W-1:0] OFF_SRAM1_ERR_COUNT  = 12'h0f4;
  localparam logic [ADDR_W-1:0] OFF_SRAM0_ERR_ADDR   = 12'h10c;
  localparam logic [ADDR_W-1:0] OFF_SRAM1_ERR_ADDR   = 12'h110;
  localparam logic [ADDR_W-1:0] OFF_MASTERS_4_5_SEC  = 12'h128;
  localparam logic [ADDR_W-1:0] OFF_MASTERS_3_7_SEC  = 12'h12c;
  localparam logic [ADDR_W-1:0] OFF_MASTER_9_SEC     = 12'h130;
  localparam logic [ADDR_W-1:0] OFF_CHIP_STATUS      = 12'h140;
  localparam logic [ADDR_W-1:0] OFF_NVM_PROTECT_USER = 12'h144;
  localparam logic [ADDR_W-1:0] OFF_NVM_SHADOW       = 12'h148;
  localparam logic [ADDR_W-1:0] OFF_PART_REVISION    = 12'h14c;
  localparam logic [ADDR_W-1:0] OFF_DDR_PLL_STATUS   = 12'h150;
  localparam logic [ADDR_W-1:0] OFF_NVM_BUSY         = 12'h158;
  localparam logic [ADDR_W-1:0] OFF_DDR_BRIDGE_STAT  = 12'h160;
  localparam logic [ADDR_W-1:0] OFF_DDR_IO_CALIB     = 12'h164;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CALIB      = 12'h168;
  localparam logic [ADDR_W-1:0] OFF_FABRIC_PROTECT_SIZE    = 12'h184;
  localparam logic [ADDR_W-1:0] OFF_FABRIC_PROTECT_BASE    = 12'h188;
  localparam logic [ADDR_W-1:0] OFF_SRAM_ERR_FLAGS   = 12'h190;
  localparam logic [ADDR_W-1:0] OFF_INTERNAL_FLAGS   = 12'h194;
  localparam logic [ADDR_W-1:0] OFF_EXTERNAL_FLAGS   = 12'h198;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_COUNTERS   = 12'h1a4;
  localparam logic [ADDR_W-1:0] OFF_FLUSH_CONTROL    = 12'h1a8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS       = 12'h1b0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE       = 12'h1b4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR        = 12'h1b8;

  // Field positions
  localparam int SRAM_FLAG_W     = 4;
  localparam int IRQ_W           = 6;
  localparam int BIT_CLR_PULSE   = 0;
  localparam int BIT_FLUSH_PULSE = 0;
  localparam int IRQ_DDR_DMA     = 4;
  localparam int IRQ_DDR_BUS     = 5;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic              sec;
    logic              ded;
    logic [DATA_W-1:0] addr;
  } mss_sram_ev_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] addr;
  } mss_ddr_err_t;

  typedef struct packed {
    logic [DATA_W-1:0] mm45;
    logic [DATA_W-1:0] mm37;
    logic [DATA_W-1:0] mm9;
    logic [DATA_W-1:0] nvm_prot;
    logic [DATA_W-1:0] fab_size;
    logic [DATA_W-1:0] fab_base;
  } mss_flash_cfg_t;

endpackage

// >>> verilog/mss_err_counter.sv
// Single-bit and double-bit error counters of one on-chip SRAM.
// Assumes error strobes and the clear pulse come from the same clock.
`timescale 1ns/1ps
module mss_err_counter #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  // Events
  input  wire logic               clr_in,
  input  wire logic               sec_in,
  input  wire logic               ded_in,
  // Count word, double-bit count high
  output logic      [2*CNT_W-1:0] count_out
);

  logic [CNT_W-1:0] sec_cnt_r;
  logic [CNT_W-1:0] ded_cnt_r;
  logic [CNT_W-1:0] sec_cnt_nxt;
  logic [CNT_W-1:0] ded_cnt_nxt;

  // Saturate rather than wrap so a flood never reads as few errors
  wire sec_full = &sec_cnt_r;
  wire ded_full = &ded_cnt_r;
  // An event in the clearing cycle counts as the first one
  assign sec_cnt_nxt = clr_in ? CNT_W'(sec_in)
                     : sec_cnt_r + CNT_W'(sec_in && !sec_full);  // [R02]
  assign ded_cnt_nxt = clr_in ? CNT_W'(ded_in)
                     : ded_cnt_r + CNT_W'(ded_in && !ded_full);  // [R02]

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_cnt_r <= '0;
      ded_cnt_r <= '0;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;  // [R01]
      ded_cnt_r <= ded_cnt_nxt;  // [R01]
    end
  end

  assign count_out = {ded_cnt_r, sec_cnt_r};

  a_clear_zeroes_count: assert property (  // [R02]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    clr_in && !sec_in && !ded_in |=> (sec_cnt_r == '0) && (ded_cnt_r == '0))
    else $error("Error counter not zero after clear");

  a_sec_counts_up: assert property (  // [R01]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !clr_in && sec_in && !sec_full |=> sec_cnt_r == $past(sec_cnt_r) + 1'b1)
    else $error("Single-bit count did not advance");

endmodule // mss_err_counter

// >>> verilog/mss_status_regs.sv
// Status and clear-type register bank of the memory subsystem, APB slave.
// Assumes all event and status inputs are driven by logic on core_clk_in.
// Overview of operation
// R01: Per-SRAM read-only single/double error counters
// R02: Write one clears both 16-bit counter sets
// R03: Capture address of each SRAM SECDED error
// R04: SRAM error flags sticky until written one
// R05: Internal and external flags, write one clears
// R06: Read-only DDR bridge failing transfer addresses
// R07: Read-only buffer empty and disabled status
// R08: Master permission registers loaded, not bus-written
// R09: NVM protect configuration loaded from flash bits
// R10: Read-only fabric protected base and size
// R11: Read-only busy state of both NVMs
// R12: DDR I/O calibration, shadow status cleared by power-on only
// R13: Write one to flush issues one-cycle pulse
// R14: Reserved reads zero, illegal writes ignored
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module mss_status_regs
  import mss_pkg::*;
#(
  // Arbitrary revision value, not a real part code
  parameter logic [31:0] PART_REVISION = 32'h0000_0001
) (
  // Clock and resets
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   power_on_reset_n_in,
  // APB slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [mss_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [mss_pkg::DATA_W-1:0] pwdata_in,
  output logic      [mss_pkg::DATA_W-1:0] prdata_out,
  output logic                        pready_out,
  // SRAM error events
  input  wire mss_pkg::mss_sram_ev_t  sram_zero_ev_in,
  input  wire mss_pkg::mss_sram_ev_t  sram_one_ev_in,
  // DDR bridge
  input  wire mss_pkg::mss_ddr_err_t  ddr_dma_err_in,
  input  wire mss_pkg::mss_ddr_err_t  ddr_bus_err_in,
  input  wire logic [mss_pkg::DATA_W-1:0] ddr_buf_empty_in,
  input  wire logic [mss_pkg::DATA_W-1:0] ddr_buf_disable_in,
  input  wire logic [mss_pkg::DATA_W-1:0] ddr_bridge_stat_in,
  // Flash-loaded configuration
  input  wire logic                   cfg_load_in,
  input  wire mss_pkg::mss_flash_cfg_t flash_cfg_in,
  // Other status sources
  input  wire logic [1:0]             nvm_busy_in,
  input  wire logic [mss_pkg::DATA_W-1:0] chip_status_in,
  input  wire logic [mss_pkg::DATA_W-1:0] nvm_shadow_in,
  input  wire logic [mss_pkg::DATA_W-1:0] ddr_pll_status_in,
  input  wire logic [mss_pkg::DATA_W-1:0] ddr_io_calib_in,
  input  wire logic [mss_pkg::DATA_W-1:0] clock_calib_in,
  input  wire logic [mss_pkg::FLAG_W-1:0] internal_ev_in,
  input  wire logic [mss_pkg::FLAG_W-1:0] external_ev_in,
  // Pulses and interrupt
  output logic                        flush_pulse_out,
  output logic                        clr_counters_out,
  output logic                        irq_out
);
  import mss_pkg::*;

  // Bus handshake
  logic              pready_r;
  logic [DATA_W-1:0] prdata_r;
  wire setup_phase = psel_in && !penable_in;
  wire wr_commit   = psel_in && penable_in && pwrite_in && pready_r;
  wire [DATA_W-1:0] wdata = pwdata_in;

  // Address decode
  wire sel_dma_adr  = paddr_in == OFF_DDR_DMA_ERR_ADDR;
  wire sel_bus_adr  = paddr_in == OFF_DDR_BUS_ERR_ADDR;
  wire sel_buf_emp  = paddr_in == OFF_DDR_BUF_EMPTY;
  wire sel_buf_dis  = paddr_in == OFF_DDR_BUF_DISABLE;
  wire sel_cnt0     = paddr_in == OFF_SRAM0_ERR_COUNT;
  wire sel_cnt1     = paddr_in == OFF_SRAM1_ERR_COUNT;
  wire sel_adr0     = paddr_in == OFF_SRAM0_ERR_ADDR;
  wire sel_adr1     = paddr_in == OFF_SRAM1_ERR_ADDR;
  wire sel_mm45     = paddr_in == OFF_MASTERS_4_5_SEC;
  wire sel_mm37     = paddr_in == OFF_MASTERS_3_7_SEC;
  wire sel_mm9      = paddr_in == OFF_MASTER_9_SEC;
  wire sel_chip     = paddr_in == OFF_CHIP_STATUS;
  wire sel_nvm_prot = paddr_in == OFF_NVM_PROTECT_USER;
  wire sel_shadow   = paddr_in == OFF_NVM_SHADOW;
  wire sel_rev      = paddr_in == OFF_PART_REVISION;
  wire sel_pll      = paddr_in == OFF_DDR_PLL_STATUS;
  wire sel_busy     = paddr_in == OFF_NVM_BUSY;
  wire sel_ddr_stat = paddr_in == OFF_DDR_BRIDGE_STAT;
  wire sel_io_cal   = paddr_in == OFF_DDR_IO_CALIB;
  wire sel_clk_cal  = paddr_in == OFF_CLOCK_CALIB;
  wire sel_fab_size = paddr_in == OFF_FABRIC_PROTECT_SIZE;
  wire sel_fab_base = paddr_in == OFF_FABRIC_PROTECT_BASE;
  wire sel_sram_flg = paddr_in == OFF_SRAM_ERR_FLAGS;
  wire sel_int_flg  = paddr_in == OFF_INTERNAL_FLAGS;
  wire sel_ext_flg  = paddr_in == OFF_EXTERNAL_FLAGS;
  wire sel_clr_cnt  = paddr_in == OFF_CLEAR_COUNTERS;
  wire sel_flush    = paddr_in == OFF_FLUSH_CONTROL;
  wire sel_irq_stat = paddr_in == OFF_IRQ_STATUS;
  wire sel_irq_en   = paddr_in == OFF_IRQ_ENABLE;
  wire sel_irq_clr  = paddr_in == OFF_IRQ_CLEAR;

  // Write strobes; writes elsewhere fall through unused [R14]
  wire wr_sram_flg = wr_commit && sel_sram_flg;
  wire wr_int_flg  = wr_commit && sel_int_flg;
  wire wr_ext_flg  = wr_commit && sel_ext_flg;
  wire wr_irq_en   = wr_commit && sel_irq_en;
  wire wr_irq_clr  = wr_commit && sel_irq_clr;
  wire clr_cnt_req = wr_commit && sel_clr_cnt && wdata[BIT_CLR_PULSE];    // [R02]
  wire flush_req   = wr_commit && sel_flush && wdata[BIT_FLUSH_PULSE];    // [R13]

  // State registers
  logic [DATA_W-1:0]      dma_adr_r;
  logic [DATA_W-1:0]      bus_adr_r;
  logic [DATA_W-1:0]      buf_emp_r;
  logic [DATA_W-1:0]      buf_dis_r;
  logic [DATA_W-1:0]      sram_adr_r [2];
  logic [DATA_W-1:0]      chip_r;
  logic [DATA_W-1:0]      pll_r;
  logic [DATA_W-1:0]      ddr_stat_r;
  logic [DATA_W-1:0]      clk_cal_r;
  logic [1:0]             busy_r;
  mss_flash_cfg_t         cfg_r;
  logic [DATA_W-1:0]      shadow_r;
  logic [DATA_W-1:0]      io_cal_r;
  logic [SRAM_FLAG_W-1:0] sram_flg_r;
  logic [FLAG_W-1:0]      int_flg_r;
  logic [FLAG_W-1:0]      ext_flg_r;
  logic [IRQ_W-1:0]       irq_stat_r;
  logic [IRQ_W-1:0]       irq_en_r;
  logic                   irq_r;
  logic                   flush_r;
  logic                   clr_cnt_r;
  logic [2*CNT_W-1:0]     cnt_word [2];
  logic [DATA_W-1:0]      rd_mux;

  // Per-SRAM counters and address capture
  mss_sram_ev_t sram_ev [2];
  assign sram_ev[0] = sram_zero_ev_in;
  assign sram_ev[1] = sram_one_ev_in;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sram
      mss_err_counter #(
        .CNT_W (CNT_W)
      ) u_cnt (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clr_in      (clr_cnt_r),
        .sec_in      (sram_ev[g].sec),
        .ded_in      (sram_ev[g].ded),
        .count_out   (cnt_word[g])
      );

      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sram_adr_r[g] <= RST_WORD;
        end else if (sram_ev[g].sec || sram_ev[g].ded) begin
          sram_adr_r[g] <= sram_ev[g].addr;  // [R03]
        end
      end
    end
  endgenerate

  // Sticky flag updates; a new event beats a same-cycle clear
  wire [SRAM_FLAG_W-1:0] sram_ev_vec = {sram_ev[1].ded, sram_ev[1].sec,
                                        sram_ev[0].ded, sram_ev[0].sec};
  wire [SRAM_FLAG_W-1:0] sram_flg_clr = wr_sram_flg ? wdata[SRAM_FLAG_W-1:0] : '0;
  wire [FLAG_W-1:0]      int_flg_clr  = wr_int_flg ? wdata[FLAG_W-1:0] : '0;
  wire [FLAG_W-1:0]      ext_flg_clr  = wr_ext_flg ? wdata[FLAG_W-1:0] : '0;
  wire [IRQ_W-1:0]       irq_clr      = wr_irq_clr ? wdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0]       irq_ev       = {ddr_bus_err_in.valid, ddr_dma_err_in.valid,
                                         sram_ev_vec};
  wire [SRAM_FLAG_W-1:0] sram_flg_nxt = (sram_flg_r & ~sram_flg_clr) | sram_ev_vec; // [R04]
  wire [FLAG_W-1:0]      int_flg_nxt  = (int_flg_r & ~int_flg_clr) | internal_ev_in; // [R05]
  wire [FLAG_W-1:0]      ext_flg_nxt  = (ext_flg_r & ~ext_flg_clr) | external_ev_in; // [R05]
  wire [IRQ_W-1:0]       irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;

  // System-reset state
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_adr_r  <= RST_WORD;
      bus_adr_r  <= RST_WORD;
      buf_emp_r  <= RST_WORD;
      buf_dis_r  <= RST_WORD;
      chip_r     <= RST_WORD;
      pll_r      <= RST_WORD;
      ddr_stat_r <= RST_WORD;
      clk_cal_r  <= RST_WORD;
      busy_r     <= '0;
      sram_flg_r <= '0;
      int_flg_r  <= '0;
      ext_flg_r  <= '0;
    end else begin
      if (ddr_dma_err_in.valid) begin
        dma_adr_r <= ddr_dma_err_in.addr;  // [R06]
      end
      if (ddr_bus_err_in.valid) begin
        bus_adr_r <= ddr_bus_err_in.addr;  // [R06]
      end
      buf_emp_r  <= ddr_buf_empty_in;      // [R07]
      buf_dis_r  <= ddr_buf_disable_in;    // [R07]
      chip_r     <= chip_status_in;
      pll_r      <= ddr_pll_status_in;
      ddr_stat_r <= ddr_bridge_stat_in;
      clk_cal_r  <= clock_calib_in;
      busy_r     <= nvm_busy_in;           // [R11]
      sram_flg_r <= sram_flg_nxt;
      int_flg_r  <= int_flg_nxt;
      ext_flg_r  <= ext_flg_nxt;
    end
  end

  // Flash-loaded words; only the load strobe changes them, never the bus
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_r <= '0;
    end else if (cfg_load_in) begin
      cfg_r <= flash_cfg_in;  // [R08] [R09] [R10]
    end
  end

  // Power-on state survives system reset
  always_ff @(posedge core_clk_in or negedge power_on_reset_n_in) begin
    if (!power_on_reset_n_in) begin
      shadow_r <= RST_WORD;  // [R12]
      io_cal_r <= RST_WORD;  // [R12]
    end else begin
      shadow_r <= nvm_shadow_in;
      io_cal_r <= ddr_io_calib_in;
    end
  end

  // Interrupt, pulses and bus answer
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      irq_r      <= 1'b0;
      flush_r    <= 1'b0;
      clr_cnt_r  <= 1'b0;
      pready_r   <= 1'b0;
      prdata_r   <= RST_WORD;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_irq_en) begin
        irq_en_r <= wdata[IRQ_W-1:0];
      end
      irq_r     <= |(irq_stat_r & irq_en_r);
      flush_r   <= flush_req;    // [R13]
      clr_cnt_r <= clr_cnt_req;  // [R02]
      pready_r  <= setup_phase;
      if (setup_phase) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // Read mux; unmapped and write-only offsets read zero [R14]
  assign rd_mux =
      ({DATA_W{sel_dma_adr}}  & dma_adr_r)
    | ({DATA_W{sel_bus_adr}}  & bus_adr_r)
    | ({DATA_W{sel_buf_emp}}  & buf_emp_r)
    | ({DATA_W{sel_buf_dis}}  & buf_dis_r)
    | ({DATA_W{sel_cnt0}}     & cnt_word[0])
    | ({DATA_W{sel_cnt1}}     & cnt_word[1])
    | ({DATA_W{sel_adr0}}     & sram_adr_r[0])
    | ({DATA_W{sel_adr1}}     & sram_adr_r[1])
    | ({DATA_W{sel_mm45}}     & cfg_r.mm45)
    | ({DATA_W{sel_mm37}}     & cfg_r.mm37)
    | ({DATA_W{sel_mm9}}      & cfg_r.mm9)
    | ({DATA_W{sel_chip}}     & chip_r)
    | ({DATA_W{sel_nvm_prot}} & cfg_r.nvm_prot)
    | ({DATA_W{sel_shadow}}   & shadow_r)
    | ({DATA_W{sel_rev}}      & PART_REVISION)
    | ({DATA_W{sel_pll}}      & pll_r)
    | ({DATA_W{sel_busy}}     & {30'h0, busy_r})
    | ({DATA_W{sel_ddr_stat}} & ddr_stat_r)
    | ({DATA_W{sel_io_cal}}   & io_cal_r)
    | ({DATA_W{sel_clk_cal}}  & clk_cal_r)
    | ({DATA_W{sel_fab_size}} & cfg_r.fab_size)
    | ({DATA_W{sel_fab_base}} & cfg_r.fab_base)
    | ({DATA_W{sel_sram_flg}} & {28'h0, sram_flg_r})
    | ({DATA_W{sel_int_flg}}  & int_flg_r)
    | ({DATA_W{sel_ext_flg}}  & ext_flg_r)
    | ({DATA_W{sel_irq_stat}} & {26'h0, irq_stat_r})
    | ({DATA_W{sel_irq_en}}   & {26'h0, irq_en_r});

  assign prdata_out       = prdata_r;
  assign pready_out       = pready_r;
  assign irq_out          = irq_r;
  assign flush_pulse_out  = flush_r;
  assign clr_counters_out = clr_cnt_r;

  wire mapped = sel_dma_adr | sel_bus_adr | sel_buf_emp | sel_buf_dis | sel_cnt0
              | sel_cnt1 | sel_adr0 | sel_adr1 | sel_mm45 | sel_mm37 | sel_mm9
              | sel_chip | sel_nvm_prot | sel_shadow | sel_rev | sel_pll | sel_busy
              | sel_ddr_stat | sel_io_cal | sel_clk_cal | sel_fab_size | sel_fab_base
              | sel_sram_flg | sel_int_flg | sel_ext_flg | sel_irq_stat | sel_irq_en;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_flush_one_cycle: assert property (  // [R13]
    flush_req |=> flush_r ##1 !flush_r)
    else $error("Flush pulse not exactly one cycle");

  a_flush_cause: assert property (  // [R13]
    flush_r |-> $past(flush_req))
    else $error("Flush pulse without a write of one");

  a_sram_flag_sticky: assert property (  // [R04]
    sram_flg_r[0] && !(wr_sram_flg && wdata[0]) |=> sram_flg_r[0])
    else $error("SRAM flag dropped without a clear");

  a_sram_flag_set: assert property (  // [R04]
    sram_ev[1].ded |=> sram_flg_r[3])
    else $error("Double-bit flag not set on event");

  a_int_flag_clear: assert property (  // [R05]
    wr_int_flg && wdata[0] && !internal_ev_in[0] |=> !int_flg_r[0])
    else $error("Internal flag not cleared by write one");

  a_ext_flag_set_wins: assert property (  // [R05]
    external_ev_in[0] |=> ext_flg_r[0])
    else $error("External event lost");

  a_sram_addr_capture: assert property (  // [R03]
    sram_ev[0].sec || sram_ev[0].ded |=> sram_adr_r[0] == $past(sram_ev[0].addr))
    else $error("SRAM error address not captured");

  a_dma_addr_capture: assert property (  // [R06]
    ddr_dma_err_in.valid |=> dma_adr_r == $past(ddr_dma_err_in.addr))
    else $error("DDR error address not captured");

  a_cfg_not_bus: assert property (  // [R08]
    !cfg_load_in |=> cfg_r == $past(cfg_r))
    else $error("Flash-loaded word changed without load");

  a_busy_reads: assert property (  // [R11]
    psel_in && !penable_in && !pwrite_in && sel_busy
      |=> prdata_r == {30'h0, $past(busy_r)})
    else $error("NVM busy read mismatch");

  a_unmapped_zero: assert property (  // [R14]
    setup_phase && !mapped |=> pready_r && prdata_r == RST_WORD)
    else $error("Unmapped offset did not read zero");

  a_buf_status: assert property (  // [R07]
    rst_n_in |=> buf_emp_r == $past(ddr_buf_empty_in))
    else $error("Buffer empty status not tracking");

  a_clr_counters: assert property (  // [R02]
    clr_cnt_req |=> clr_cnt_r ##1 !clr_cnt_r)
    else $error("Counter clear pulse not one cycle");

endmodule // mss_status_regs

// >>> test/tb_top.sv
// Self-checking bench for the status register bank over APB.
// Assumes a zero-wait APB slave and event inputs on the same clock.
`timescale 1ns/1ps
module tb_top;
  import mss_pkg::*;
  logic              clk, rst_n, por_n, psel, pen, pwr, flush, clr, irq, pready, cfg_ld;
  logic [ADDR_W-1:0] paddr, a;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] lv [8];
  logic [ADDR_W-1:0] ra [20];
  logic [DATA_W-1:0] re [20];
  mss_sram_ev_t      ev0, ev1;
  mss_ddr_err_t      de0, de1;
  mss_flash_cfg_t    fc;
  logic [1:0]        busy;
  logic [FLAG_W-1:0] iev, xev;
  int                miscompares, tests_run;

  mss_status_regs mss_status_regs_i (
    .core_clk_in(clk), .rst_n_in(rst_n), .power_on_reset_n_in(por_n),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .sram_zero_ev_in(ev0), .sram_one_ev_in(ev1), .ddr_dma_err_in(de0), .ddr_bus_err_in(de1),
    .ddr_buf_empty_in(lv[0]), .ddr_buf_disable_in(lv[1]), .ddr_bridge_stat_in(lv[2]),
    .cfg_load_in(cfg_ld), .flash_cfg_in(fc), .nvm_busy_in(busy), .chip_status_in(lv[3]),
    .nvm_shadow_in(lv[4]), .ddr_pll_status_in(lv[5]), .ddr_io_calib_in(lv[6]),
    .clock_calib_in(lv[7]), .internal_ev_in(iev), .external_ev_in(xev),
    .flush_pulse_out(flush), .clr_counters_out(clr), .irq_out(irq));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  // Request held from setup until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    int k;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 0; pen <= 0;
    if (k >= 50) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
    apb(0, ad, '0);
    chk(rd, e);
  endtask

  initial begin
    rst_n = 0; por_n = 0; psel = 0; pen = 0; pwr = 0; paddr = '0; pwdata = '0;
    ev0 = '0; ev1 = '0; de0 = '0; de1 = '0; cfg_ld = 0; busy = 2'b10; iev = '0; xev = '0;
    for (int i = 0; i < 8; i++) lv[i] = 32'h5a5a_0000 | 32'(i);
    fc = '{32'hc001_0128, 32'hc001_012c, 32'hc001_0130, 32'hc001_0144, 32'hc001_0184,
           32'hc001_0188};
    ra = '{12'h0e8, 12'h0ec, 12'h160, 12'h140, 12'h148, 12'h150, 12'h164, 12'h168, 12'h14c,
           12'h158, 12'h128, 12'h12c, 12'h130, 12'h144, 12'h184, 12'h188, 12'h0f8, 12'h154,
           12'h1ac, 12'h1a4};
    re = '{lv[0], lv[1], lv[2], lv[3], lv[4], lv[5], lv[6], lv[7], 32'h1, 32'h2, fc.mm45,
           fc.mm37, fc.mm9, fc.nvm_prot, fc.fab_size, fc.fab_base, '0, '0, '0, '0};
    repeat (2) @(posedge clk);
    rst_n <= 1; por_n <= 1;
    @(posedge clk) cfg_ld <= 1;
    @(posedge clk) cfg_ld <= 0;
    // Each row is first written with ones, which must not stick
    for (int i = 0; i < 20; i++) begin
      apb(1, ra[i], 32'hffff_ffff);
      rdchk(ra[i], re[i]);
    end
    apb(1, OFF_IRQ_ENABLE, 32'h1);
    @(posedge clk) begin
      ev0 <= '{1'b1, 1'b0, 32'h0000_1230};
      ev1 <= '{1'b0, 1'b1, 32'h0000_4560};
    end
    @(posedge clk) begin ev0 <= '0; ev1 <= '0; end
    @(posedge clk) #1 chk(irq, 1);
    rdchk(OFF_SRAM0_ERR_COUNT, 32'h0000_0001);
    rdchk(OFF_SRAM1_ERR_COUNT, 32'h0001_0000);
    rdchk(OFF_SRAM0_ERR_ADDR, 32'h0000_1230);
    rdchk(OFF_SRAM1_ERR_ADDR, 32'h0000_4560);
    rdchk(OFF_SRAM_ERR_FLAGS, 32'h9);
    apb(1, OFF_SRAM_ERR_FLAGS, 32'h1);
    rdchk(OFF_SRAM_ERR_FLAGS, 32'h8);
    apb(1, OFF_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(irq, 0);
    apb(1, OFF_IRQ_CLEAR, 32'h3f);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    // Both pulse registers: one-cycle pulse on a one, nothing on a zero
    for (int j = 0; j < 2; j++) begin
      a = j ? OFF_FLUSH_CONTROL : OFF_CLEAR_COUNTERS;
      apb(1, a, 32'h1);
      #1 chk(j ? flush : clr, 1);
      @(posedge clk) #1 chk(j ? flush : clr, 0);
      apb(1, a, 32'h0);
      #1 chk(j ? flush : clr, 0);
    end
    rdchk(OFF_SRAM0_ERR_COUNT, 32'h0);
    rdchk(OFF_SRAM1_ERR_COUNT, 32'h0);
    @(posedge clk) begin de0 <= '{1'b1, 32'hdd00_00e0}; de1 <= '{1'b1, 32'hdd00_00e4}; end
    @(posedge clk) begin de0 <= '0; de1 <= '0; end
    rdchk(OFF_DDR_DMA_ERR_ADDR, 32'hdd00_00e0);
    rdchk(OFF_DDR_BUS_ERR_ADDR, 32'hdd00_00e4);
    rdchk(OFF_IRQ_STATUS, 32'h30);
    for (int j = 0; j < 2; j++) begin
      a = j ? OFF_EXTERNAL_FLAGS : OFF_INTERNAL_FLAGS;
      @(posedge clk) if (j) xev <= 32'h9; else iev <= 32'h9;
      @(posedge clk) begin iev <= '0; xev <= '0; end
      rdchk(a, 32'h9);
      apb(1, a, 32'h9);
      rdchk(a, 32'h0);
    end
    // Power-on reset alone hits only the DDR I/O calibration and shadow words
    @(posedge clk) por_n <= 0;
    rdchk(OFF_DDR_IO_CALIB, 32'h0);
    rdchk(OFF_CLOCK_CALIB, lv[7]);
    @(posedge clk) por_n <= 1;
    @(posedge clk) rst_n <= 0;
    repeat (2) @(posedge clk);
    #1 chk(pready, 0);
    chk(irq, 0);
    // Calibration copy must ride through a system reset
    chk(mss_status_regs_i.io_cal_r, lv[6]);
    @(posedge clk) rst_n <= 1;
    rdchk(OFF_SRAM_ERR_FLAGS, 32'h0);
    rdchk(OFF_DDR_DMA_ERR_ADDR, 32'h0);
    final_report();
  end
endmodule // tb_top
